// >>> src/pef_top.sv
`timescale 1ns/1ns
`default_nettype none
module pef_top
  import pef_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic encoder_kind_jumper,
  input wire logic polarity_redundancy_jumper,
  input wire logic code_or_dual_select_jumper,
  input wire logic [POS_W-1:0] enc_in,
  input wire logic ser_req,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output pef_pkg::pef_quad_t fb_quad,
  output logic ser_bit,
  output logic ser_vld,
  output logic fault
);

  // ------------------------------------------------------------
  // Input sampling and mode decode
  // ------------------------------------------------------------
  logic [POS_W-1:0] enc_r, enc_nxt;
  pef_mode_t mode_r, mode_nxt;
  logic pol_r, code_r, pol_nxt, code_nxt;

  always_comb begin
    enc_nxt = enc_in;
    pol_nxt = polarity_redundancy_jumper;
    code_nxt = code_or_dual_select_jumper;
    mode_nxt = pef_decode_mode(encoder_kind_jumper, polarity_redundancy_jumper,
                               code_or_dual_select_jumper);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enc_r <= '0;
      mode_r <= MODE_SINGLE;
      pol_r <= 1'b1;
      code_r <= 1'b1;
    end else begin
      enc_r <= enc_nxt;
      mode_r <= mode_nxt;
      pol_r <= pol_nxt;
      code_r <= code_nxt;
    end
  end

  // ------------------------------------------------------------
  // Absolute position path
  // ------------------------------------------------------------
  // Bits 0..5 carry A1 B1 Z1 A2 B2 Z2 in quadrature modes.
  pef_quad_t prim_q, sec_q;
  logic [POS_W-1:0] pol_word, pos_nxt, pos_r;
  logic abs_mode;

  always_comb begin
    prim_q = '{a: enc_r[0], b: enc_r[1], z: enc_r[2]};
    sec_q = '{a: enc_r[3], b: enc_r[4], z: enc_r[5]};
    abs_mode = (mode_r == MODE_ABS);
    pol_word = pol_r ? ~enc_r : enc_r;
    pos_nxt = code_r ? pef_gray2bin(pol_word) : pol_word;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // ------------------------------------------------------------
  // Control register and encoder selection
  // ------------------------------------------------------------
  logic sel_r, sel_nxt, use_sec_r, use_sec_nxt;
  logic prim_fault;

  pef_quad_mon u_mon (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(mode_r == MODE_REDUN),
    .quad(prim_q),
    .fault(prim_fault)
  );

  always_comb begin
    sel_nxt = sel_r;
    if (reg_wr && (reg_addr == REG_CTRL)) begin
      sel_nxt = reg_wdata[CTRL_SEL_BIT];
    end
    use_sec_nxt = 1'b0;
    case (mode_r)
      MODE_DUAL: use_sec_nxt = sel_r;
      MODE_REDUN: use_sec_nxt = use_sec_r | prim_fault;
      MODE_SINGLE: use_sec_nxt = 1'b0;
      default: use_sec_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_r <= CTRL_RST[CTRL_SEL_BIT];
      use_sec_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      use_sec_r <= use_sec_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pseudo quadrature
  // ------------------------------------------------------------
  localparam logic [7:0] STEP_LAST = 8'(QUAD_STEP_CYC - 1);
  logic [7:0] div_r, div_nxt;
  logic step_r, step_nxt;
  pef_quad_t pseudo_q;

  always_comb begin
    step_nxt = (div_r == STEP_LAST);
    div_nxt = step_nxt ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_r <= 8'h00;
      step_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      step_r <= step_nxt;
    end
  end

  pef_pseudo_quad #(.W(POS_W)) u_pseudo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .step_en(step_r),
    .target(pos_r),
    .quad(pseudo_q)
  );

  // ------------------------------------------------------------
  // Feedback outputs
  // ------------------------------------------------------------
  pef_quad_t fb_r, fb_nxt;

  always_comb begin
    if (abs_mode) begin
      fb_nxt = pseudo_q;
    end else if (use_sec_r) begin
      fb_nxt = sec_q;
    end else begin
      fb_nxt = prim_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fb_r <= '0;
    end else begin
      fb_r <= fb_nxt;
    end
  end

  // ------------------------------------------------------------
  // Serialiser
  // ------------------------------------------------------------
  logic [POS_W-1:0] sh_r, sh_nxt;
  logic [3:0] left_r, left_nxt;
  logic sbit_r, sbit_nxt, svld_r, svld_nxt, take;

  always_comb begin
    sh_nxt = sh_r;
    left_nxt = left_r;
    sbit_nxt = sbit_r;
    svld_nxt = 1'b0;
    take = ser_req && abs_mode && (left_r == 4'h0);
    if (take) begin
      sbit_nxt = pos_r[POS_W-1];
      sh_nxt = {pos_r[POS_W-2:0], 1'b0};
      left_nxt = 4'(POS_W - 1);
      svld_nxt = 1'b1;
    end else if (left_r != 4'h0) begin
      sbit_nxt = sh_r[POS_W-1];
      sh_nxt = {sh_r[POS_W-2:0], 1'b0};
      left_nxt = left_r - 4'h1;
      svld_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sh_r <= '0;
      left_r <= 4'h0;
      sbit_r <= 1'b0;
      svld_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      left_r <= left_nxt;
      sbit_r <= sbit_nxt;
      svld_r <= svld_nxt;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;
  logic fault_r;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_nxt[CTRL_SEL_BIT] = sel_r;
        REG_STAT: begin
          rdata_nxt[STAT_MODE_LSB +: 2] = mode_r;
          rdata_nxt[STAT_SEC_BIT] = use_sec_r;
          rdata_nxt[STAT_FAULT_BIT] = prim_fault;
          rdata_nxt[STAT_SER_BIT] = svld_r;
        end
        REG_POS: rdata_nxt[POS_W-1:0] = pos_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
      fault_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      fault_r <= prim_fault;
    end
  end

  assign reg_rdata = rdata_r;
  assign fb_quad = fb_r;
  assign ser_bit = sbit_r;
  assign ser_vld = svld_r;
  assign fault = fault_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_default_single: assert property (encoder_kind_jumper && polarity_redundancy_jumper
    && code_or_dual_select_jumper |=> mode_r == MODE_SINGLE ##1 !use_sec_r)
    else $error("default jumpers not single");
  a_absolute_mode: assert property (!encoder_kind_jumper |=> mode_r == MODE_ABS)
    else $error("absolute mode not selected");
  a_dual_choice: assert property (mode_r == MODE_DUAL && sel_r |=> use_sec_r ##1 fb_r == $past(sec_q))
    else $error("dual select not honoured");
  a_redun_switch: assert property (mode_r == MODE_REDUN && prim_fault |=> use_sec_r)
    else $error("no switch-over on fault");
  a_sec_latched: assert property (mode_r == MODE_REDUN && use_sec_r |=> use_sec_r)
    else $error("secondary released");
  a_serial_req: assert property ($rose(svld_r) |-> $past(ser_req) && $past(abs_mode))
    else $error("serial data without request");
  a_serial_len: assert property ($rose(svld_r) |-> svld_r [*8])
    else $error("serial frame too short");
  a_first_bit: assert property (take |=> sbit_r == $past(pos_r[POS_W-1]))
    else $error("serial first bit wrong");
  a_gray_low: assert property (code_r && !pol_r |=> (pos_r ^ (pos_r >> 1)) == $past(enc_r))
    else $error("gray low-true conversion wrong");
  a_bin_low: assert property (!code_r && !pol_r |=> pos_r == $past(enc_r))
    else $error("binary low-true path wrong");
  a_gray_high: assert property (code_r && pol_r |=> (pos_r ^ (pos_r >> 1)) == ~$past(enc_r))
    else $error("gray high-true conversion wrong");
  a_bin_high: assert property (!code_r && pol_r |=> pos_r == ~$past(enc_r))
    else $error("binary high-true path wrong");
  a_step_rate: assert property (step_r |=> !step_r [*8])
    else $error("pseudo step too fast");
  a_pseudo_out: assert property (abs_mode |=> fb_r == $past(pseudo_q))
    else $error("pseudo quadrature not driven");

  c_switch_over: cover property (mode_r == MODE_REDUN && $rose(use_sec_r));
  c_serial_frame: cover property (take ##1 svld_r [*8]);
  c_dual_sec: cover property (mode_r == MODE_DUAL && use_sec_r);
  c_index: cover property (abs_mode && $rose(fb_r.z));

endmodule
`default_nettype wire

// >>> shared/pef_pkg.sv
package pef_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_POS = 8'h08;
  localparam int CTRL_SEL_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SEC_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_SER_BIT = 4;

  // ------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------
  localparam int POS_W = 12;
  localparam int CLK_HZ = 100_000_000;
  localparam int ENC_MAX_KHZ = 200;
  localparam int EDGES_PER_PERIOD = 4;
  localparam int QUAD_STEP_CYC =
    (CLK_HZ + EDGES_PER_PERIOD * ENC_MAX_KHZ * 1000 - 1) / (EDGES_PER_PERIOD * ENC_MAX_KHZ * 1000);

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_REDUN = 2'b10,
    MODE_ABS = 2'b11
  } pef_mode_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } pef_quad_t;

  // Jumper inputs are low while the jumper is installed.
  function automatic pef_mode_t pef_decode_mode(input logic kind, input logic pol, input logic code);
    pef_mode_t m;
    m = MODE_SINGLE;
    if (!kind) begin
      m = MODE_ABS;
    end else if (!code && pol) begin
      m = MODE_DUAL;
    end else if (!code && !pol) begin
      m = MODE_REDUN;
    end
    return m;
  endfunction

  function automatic logic [POS_W-1:0] pef_gray2bin(input logic [POS_W-1:0] g);
    logic [POS_W-1:0] b;
    b = '0;
    b[POS_W-1] = g[POS_W-1];
    for (int i = POS_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> src/pef_quad_mon.sv
`timescale 1ns/1ns
`default_nettype none
module pef_quad_mon
  import pef_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire pef_pkg::pef_quad_t quad,
  output logic fault
);

  logic a_r, b_r, prim_r, fault_r;
  logic a_nxt, b_nxt, prim_nxt, fault_nxt;

  // ------------------------------------------------------------
  // Illegal transition check
  // ------------------------------------------------------------
  always_comb begin
    a_nxt = quad.a;
    b_nxt = quad.b;
    prim_nxt = enable;
    fault_nxt = fault_r;
    if (prim_r && enable && (quad.a != a_r) && (quad.b != b_r)) begin
      fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      prim_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      prim_r <= prim_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign fault = fault_r;

  a_fault_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst) fault_r |=> fault_r)
    else $error("fault flag dropped");

endmodule
`default_nettype wire

// >>> src/pef_pseudo_quad.sv
`timescale 1ns/1ns
`default_nettype none
module pef_pseudo_quad
  import pef_pkg::*;
#(
  parameter int W = POS_W
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic step_en,
  input wire logic [W-1:0] target,
  output pef_pkg::pef_quad_t quad
);

  logic [W-1:0] cnt_r, cnt_nxt;
  pef_quad_t quad_r, quad_nxt;

  // ------------------------------------------------------------
  // Step generator
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (step_en && (cnt_r != target)) begin
      cnt_nxt = (target > cnt_r) ? cnt_r + 1'b1 : cnt_r - 1'b1;
    end
    quad_nxt.a = cnt_nxt[1];
    quad_nxt.b = cnt_nxt[1] ^ cnt_nxt[0];
    quad_nxt.z = (cnt_nxt == '0);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      quad_r <= '{a: 1'b0, b: 1'b0, z: 1'b1};
    end else begin
      cnt_r <= cnt_nxt;
      quad_r <= quad_nxt;
    end
  end

  assign quad = quad_r;

  a_one_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !step_en |=> cnt_r == $past(cnt_r))
    else $error("pseudo count moved without step");

endmodule
`default_nettype wire

// >>> sim/pef_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
module pef_enc_model
  import pef_pkg::*;
(
  input wire logic abs_mode,
  input wire logic gray,
  input wire logic low_true,
  input wire logic [POS_W-1:0] pos,
  input wire logic [7:0] cnt1,
  input wire logic [7:0] cnt2,
  output logic [POS_W-1:0] enc_in
);
  logic [POS_W-1:0] code;

  assign code = gray ? (pos ^ (pos >> 1)) : pos;

  always_comb begin
    if (abs_mode) begin
      enc_in = low_true ? code : ~code;
    end else begin
      enc_in = {6'h00, cnt2 == 8'h00, cnt2[1] ^ cnt2[0], cnt2[1], cnt1 == 8'h00, cnt1[1] ^ cnt1[0], cnt1[1]};
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pef_pkg::*;

  logic ref_clk, sys_rst, kind, pol, code, ser_req, reg_wr, reg_rd, ser_bit, ser_vld, fault;
  logic [7:0] reg_addr, c1, c2;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [POS_W-1:0] enc_in, p, v;
  pef_quad_t fb_quad;
  int num_errors = 0;
  int num_checks = 0;
  logic [4:0] mt [5] = '{5'h1C, 5'h14, 5'h12, 5'h19, 5'h03};
  logic [POS_W-1:0] pv [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};

  pef_enc_model enc (.abs_mode(!kind), .gray(code), .low_true(!pol), .pos(p), .cnt1(c1), .cnt2(c2),
    .enc_in(enc_in));

  pef_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .encoder_kind_jumper(kind),
    .polarity_redundancy_jumper(pol), .code_or_dual_select_jumper(code), .enc_in(enc_in),
    .ser_req(ser_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fb_quad(fb_quad), .ser_bit(ser_bit), .ser_vld(ser_vld), .fault(fault));

  always #5 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] qv(input logic [7:0] c);
    return {c[1], c[1] ^ c[0], c == 8'h00};
  endfunction

  task automatic chq(input logic [7:0] c);
    chk({29'h0, fb_quad}, {29'h0, qv(c)});
  endtask

  task automatic rst;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask

  task automatic ser(output logic [POS_W-1:0] x);
    @(posedge ref_clk);
    ser_req <= 1'b1;
    @(posedge ref_clk);
    ser_req <= 1'b0;
    #1;
    for (int i = 0; i < POS_W; i++) begin
      x = {x[POS_W-2:0], ser_vld === 1'b1 ? ser_bit : 1'bx};
      tick(1);
    end
    chk({31'h0, ser_vld}, 32'h0);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #200_000;
    num_errors++;
    stop_test;
  end

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {ser_req, reg_wr, reg_rd} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    p = 12'h000;
    c1 = 8'h00;
    c2 = 8'h00;
    for (int i = 0; i < 5; i++) begin
      {kind, pol, code} <= mt[i][4:2];
      rst;
      rd(REG_STAT, d);
      chk(d & 32'h3, {30'h0, mt[i][1:0]});
    end
    $display("test modes done");
    {kind, pol, code} <= 3'h7;
    rst;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      c1 <= c1 + 8'h01;
      c2 <= c2 - 8'h01;
      tick(QUAD_STEP_CYC);
      chq(c1);
    end
    @(posedge ref_clk);
    ser_req <= 1'b1;
    @(posedge ref_clk);
    ser_req <= 1'b0;
    tick(2);
    chk({31'h0, ser_vld}, 32'h0);
    $display("test single done");
    {kind, pol, code} <= 3'h6;
    rst;
    wr(REG_CTRL, 32'h1);
    tick(3);
    chq(c2);
    rd(REG_CTRL, d);
    chk(d, 32'h1);
    wr(REG_CTRL, 32'h0);
    tick(3);
    chq(c1);
    $display("test dual done");
    {kind, pol, code} <= 3'h4;
    rst;
    chk({31'h0, fault}, 32'h0);
    chq(c1);
    @(posedge ref_clk);
    c1 <= c1 + 8'h02;
    tick(6);
    chk({31'h0, fault}, 32'h1);
    chq(c2);
    @(posedge ref_clk);
    c1 <= c1 + 8'h01;
    c2 <= c2 + 8'h01;
    tick(QUAD_STEP_CYC);
    chq(c2);
    wr(REG_STAT, 32'h0);
    rd(REG_STAT, d);
    chk(d & 32'hC, 32'hC);
    rd(8'h0C, d);
    chk(d, 32'h0);
    rst;
    chk({31'h0, fault}, 32'h0);
    chq(c1);
    $display("test redundant done");
    for (int i = 0; i < 8; i++) begin
      {kind, pol, code} <= {1'b0, i[0], i[1]};
      p <= pv[i[2:1]];
      rst;
      ser(v);
      chk({20'h0, v}, {20'h0, p});
      rd(REG_POS, d);
      chk(d, {20'h0, p});
    end
    p <= 12'h003;
    rst;
    tick(500);
    chq(8'h03);
    p <= 12'h000;
    tick(500);
    chq(8'h00);
    @(posedge ref_clk);
    ser_req <= 1'b1;
    @(posedge ref_clk);
    ser_req <= 1'b0;
    rd(REG_STAT, d);
    chk(d & 32'h1F, 32'h13);
    $display("test absolute done");
    stop_test;
  end
endmodule
`default_nettype wire
